// ---- hdl/harmonic_overcurrent_stage.sv ----
// One harmonic overcurrent protection stage, evaluated per program cycle.
// Assumes preprocessed harmonic magnitudes and a shared cycle tick.
`timescale 1ns/1ns
module harmonic_overcurrent_stage #(
    parameter int HARMONICS = hoc_pkg::HARM_COUNT,
    parameter int CLK_HZ = 20000000,
    parameter int MS_COUNT = 20000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cycle_tick,
    input wire hoc_pkg::stage_settings_t settings,
    input wire logic [HARMONICS*3*hoc_pkg::MAG_W-1:0] phase_current_inputs,
    input wire logic [HARMONICS*hoc_pkg::MAG_W-1:0] residual_input_first,
    input wire logic [HARMONICS*hoc_pkg::MAG_W-1:0] residual_input_second,
    input wire hoc_pkg::three_mag_t phase_fundamental,
    input wire logic [hoc_pkg::MAG_W-1:0] residual_first_fundamental,
    input wire logic [hoc_pkg::MAG_W-1:0] residual_second_fundamental,
    input wire logic block_in,
    output logic start,
    output logic trip,
    output logic blocked,
    output hoc_pkg::stage_operating_mode_t behaviour,
    output hoc_pkg::condition_t condition,
    output logic [hoc_pkg::RATIO_W-1:0] ratio_now,
    output logic [hoc_pkg::TIME_W-1:0] expected_time,
    output logic signed [hoc_pkg::TIME_W:0] time_to_trip,
    output hoc_pkg::stage_events_t events,
    output logic [31:0] event_stamp_ms,
    output logic block_display_event,
    output hoc_pkg::three_mag_t block_currents,
    output logic [2:0] block_fault_phases
);
    import hoc_pkg::*;

    initial begin
        if (HARMONICS < 1 || HARMONICS > 16) $error("HARMONICS out of range");
        if (MS_COUNT != CLK_HZ / 1000) $error("MS_COUNT must match CLK_HZ");
    end

    // ****************************************************
    // Reset release
    // ****************************************************
    logic [1:0] rst_sync_r;
    logic rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_r[1];

    // ****************************************************
    // Input selection
    // ****************************************************
    function automatic logic [MAG_W-1:0] pick_harm(
        input logic [HARMONICS*MAG_W-1:0] vec,
        input logic [3:0] idx
    );
        logic [MAG_W-1:0] res;
        res = '0;
        for (int i = 0; i < HARMONICS; i++) begin
            if (idx == 4'(i)) res = vec[i*MAG_W +: MAG_W];
        end
        return res;
    endfunction : pick_harm

    // Percent content times 100; zero fundamental gives zero, never a trip
    function automatic logic [MAG_W-1:0] to_relative(
        input logic [MAG_W-1:0] harm,
        input logic [MAG_W-1:0] fund
    );
        logic [MAG_W+15:0] prod;
        logic [MAG_W+15:0] q;
        prod = (MAG_W+16)'(harm) * (MAG_W+16)'(PERCENT_FULL);
        q = (fund == '0) ? '0 : prod / (MAG_W+16)'(fund);
        return (q > (MAG_W+16)'({MAG_W{1'b1}})) ? '1 : q[MAG_W-1:0];
    endfunction : to_relative

    logic [MAG_W-1:0] mag [3];
    logic [MAG_W-1:0] fund [3];
    logic [MAG_W-1:0] raw [3];
    logic [2:0] over;
    logic [RATIO_W-1:0] ratio [3];

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            unique case (settings.input_sel)
                INPUT_RESIDUAL_FIRST: begin
                    raw[p] = pick_harm(residual_input_first, settings.harmonic_index);
                    fund[p] = residual_first_fundamental;
                end
                INPUT_RESIDUAL_SECOND: begin
                    raw[p] = pick_harm(residual_input_second, settings.harmonic_index);
                    fund[p] = residual_second_fundamental;
                end
                default: begin
                    raw[p] = pick_harm(phase_current_inputs[p*HARMONICS*MAG_W +:
                        HARMONICS*MAG_W], settings.harmonic_index);
                    fund[p] = phase_fundamental[(2-p)*MAG_W +: MAG_W];
                end
            endcase
            mag[p] = settings.relative_mode ? to_relative(raw[p], fund[p]) : raw[p];
        end
    end

    // Residual selection feeds one value to all three comparators
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            phase_compare #(.MAG_W(MAG_W), .RATIO_W(RATIO_W)) u_cmp (
                .mclk(mclk),
                .rst_sync_n(rst_sync_n),
                .tick(cycle_tick),
                .magnitude(mag[g]),
                .threshold(settings.pickup_threshold),
                .over(over[g]),
                .ratio(ratio[g])
            );
        end
    endgenerate

    logic pickup;
    logic [RATIO_W-1:0] ratio_max;

    always_comb begin
        pickup = |over;
        ratio_max = ratio[0];
        for (int p = 1; p < 3; p++) begin
            if (ratio[p] > ratio_max) ratio_max = ratio[p];
        end
    end

    // ****************************************************
    // Block and start/trip state
    // ****************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_TRIP = 4'b0100,
        ST_BLOCK = 4'b1000
    } stage_state_t;

    stage_state_t state_r, state_nxt;
    logic block_r, block_nxt;
    logic releasing_r, releasing_nxt;
    logic op_expired, rel_expired;
    logic mode_blocked, mode_off;
    logic [7:0] overshoot;

    always_comb begin
        mode_blocked = (settings.mode == MODE_BLOCKED) || (settings.mode == MODE_TEST_BLOCKED);
        mode_off = (settings.mode == MODE_OFF);
        overshoot = (ratio_max > RATIO_W'(25599)) ? 8'hff : 8'(ratio_max[RATIO_W-1:2] / 25);
    end

    always_comb begin
        block_nxt = block_r;
        if (cycle_tick) block_nxt = block_in | mode_blocked;
        state_nxt = state_r;
        releasing_nxt = releasing_r;
        if (mode_off) begin
            state_nxt = ST_IDLE;
            releasing_nxt = 1'b0;
        end else if (cycle_tick) begin
            if (releasing_r && rel_expired) releasing_nxt = 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (pickup && block_nxt) begin
                        state_nxt = ST_BLOCK;
                    end else if (pickup) begin
                        state_nxt = ST_START;
                        releasing_nxt = 1'b0;
                    end
                end
                ST_START: begin
                    if (block_nxt) begin
                        state_nxt = pickup ? ST_BLOCK : ST_IDLE;
                        releasing_nxt = 1'b1;
                    end else if (!pickup) begin
                        state_nxt = ST_IDLE;
                        releasing_nxt = 1'b1;
                    end else if (op_expired) begin
                        state_nxt = ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (block_nxt) begin
                        state_nxt = pickup ? ST_BLOCK : ST_IDLE;
                        releasing_nxt = 1'b1;
                    end else if (!pickup) begin
                        state_nxt = ST_IDLE;
                        releasing_nxt = 1'b1;
                    end
                end
                ST_BLOCK: begin
                    if (!pickup) state_nxt = ST_IDLE;
                    else if (!block_nxt) state_nxt = ST_START;
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= ST_IDLE;
            block_r <= 1'b0;
            releasing_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            block_r <= block_nxt;
            releasing_r <= releasing_nxt;
        end
    end

    // Operating delay; the blocking party must lead its expiry by 5 ms
    delay_timer #(.TIME_W(TIME_W)) u_operate (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .tick(cycle_tick),
        .run(state_r == ST_START),
        .inverse_time(settings.inverse_time),
        .delay(settings.operate_delay),
        .ratio_over(overshoot),
        .expired(op_expired),
        .expected(expected_time),
        .remaining(time_to_trip)
    );

    delay_timer #(.TIME_W(TIME_W)) u_release (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .tick(cycle_tick),
        .run(releasing_r),
        .inverse_time(settings.inverse_time),
        .delay(settings.release_delay),
        .ratio_over(8'h01),
        .expired(rel_expired),
        .expected(),
        .remaining()
    );

    // ****************************************************
    // Outputs, forcing and events
    // ****************************************************
    condition_t cond_nxt, cond_r;
    logic [31:0] ms_stamp_r, ms_stamp_nxt;
    logic [$clog2(MS_COUNT)-1:0] ms_div_r, ms_div_nxt;
    stage_events_t ev_nxt, ev_r;
    logic [RATIO_W-1:0] ratio_now_r, ratio_now_nxt;
    three_mag_t blk_cur_r, blk_cur_nxt;
    logic [2:0] blk_fault_r, blk_fault_nxt;
    logic blk_disp_r, blk_disp_nxt;

    always_comb begin
        unique case (state_r)
            ST_START: cond_nxt = COND_START;
            ST_TRIP: cond_nxt = COND_TRIP;
            ST_BLOCK: cond_nxt = COND_BLOCKED;
            default: cond_nxt = COND_NORMAL;
        endcase
        if (settings.force_enable) cond_nxt = settings.force_status;
        ms_div_nxt = ms_div_r + 1'b1;
        ms_stamp_nxt = ms_stamp_r;
        if (ms_div_r == ($clog2(MS_COUNT))'(MS_COUNT - 1)) begin
            ms_div_nxt = '0;
            ms_stamp_nxt = ms_stamp_r + 32'h1;
        end
        ev_nxt.start_on = (cond_nxt == COND_START) && (cond_r != COND_START);
        ev_nxt.start_off = (cond_nxt != COND_START) && (cond_r == COND_START);
        ev_nxt.trip_on = (cond_nxt == COND_TRIP) && (cond_r != COND_TRIP);
        ev_nxt.trip_off = (cond_nxt != COND_TRIP) && (cond_r == COND_TRIP);
        ev_nxt.block_on = (cond_nxt == COND_BLOCKED) && (cond_r != COND_BLOCKED);
        ev_nxt.block_off = (cond_nxt != COND_BLOCKED) && (cond_r == COND_BLOCKED);
        ratio_now_nxt = ratio_max;
        blk_cur_nxt = blk_cur_r;
        blk_fault_nxt = blk_fault_r;
        blk_disp_nxt = ev_nxt.block_on;
        if (ev_nxt.block_on) begin
            blk_cur_nxt = {raw[0], raw[1], raw[2]};
            blk_fault_nxt = over;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cond_r <= COND_NORMAL;
            ms_div_r <= '0;
            ms_stamp_r <= '0;
            ev_r <= '0;
            ratio_now_r <= '0;
            blk_cur_r <= '0;
            blk_fault_r <= '0;
            blk_disp_r <= 1'b0;
        end else begin
            cond_r <= cond_nxt;
            ms_div_r <= ms_div_nxt;
            ms_stamp_r <= ms_stamp_nxt;
            ev_r <= ev_nxt;
            ratio_now_r <= ratio_now_nxt;
            blk_cur_r <= blk_cur_nxt;
            blk_fault_r <= blk_fault_nxt;
            blk_disp_r <= blk_disp_nxt;
        end
    end

    // Settings are per-instance ports, so stages never share state
    assign behaviour = settings.mode;
    assign condition = cond_r;
    assign start = (cond_r == COND_START) || (cond_r == COND_TRIP);
    assign trip = (cond_r == COND_TRIP);
    assign blocked = (cond_r == COND_BLOCKED);
    assign ratio_now = ratio_now_r;
    assign events = ev_r;
    assign event_stamp_ms = ms_stamp_r;
    assign block_display_event = blk_disp_r;
    assign block_currents = blk_cur_r;
    assign block_fault_phases = blk_fault_r;
endmodule : harmonic_overcurrent_stage

// ---- pkg/hoc_pkg.sv ----
// Shared types and constants for one harmonic overcurrent stage.
// Assumes a 20 MHz system clock and a program-cycle tick from outside.
package hoc_pkg;

    // ****************************************************
    // Settings encodings
    // ****************************************************
    typedef enum logic [2:0] {
        MODE_ON = 3'h1,
        MODE_BLOCKED = 3'h2,
        MODE_TEST = 3'h3,
        MODE_TEST_BLOCKED = 3'h4,
        MODE_OFF = 3'h5
    } stage_operating_mode_t;

    typedef enum logic [1:0] {
        COND_NORMAL = 2'h0,
        COND_START = 2'h1,
        COND_TRIP = 2'h2,
        COND_BLOCKED = 2'h3
    } condition_t;

    typedef enum logic [1:0] {
        INPUT_PHASES = 2'h0,
        INPUT_RESIDUAL_FIRST = 2'h1,
        INPUT_RESIDUAL_SECOND = 2'h2
    } input_sel_t;

    localparam int HARM_COUNT = 11;
    localparam logic [3:0] HARM_INDEX_DEFAULT = 4'h0;

    // ****************************************************
    // Fixed-point scales
    // ****************************************************
    // Magnitudes and thresholds: per unit times 100, or percent times 100
    localparam int MAG_W = 16;
    localparam logic [MAG_W-1:0] THRESHOLD_PU_DEFAULT = 16'h0014;
    localparam logic [MAG_W-1:0] THRESHOLD_PCT_DEFAULT = 16'h07d0;
    localparam logic [MAG_W-1:0] PERCENT_FULL = 16'h2710;
    localparam int RESET_RATIO_PCT = 97;
    localparam int RATIO_W = 24;
    localparam int TIME_W = 20;
    // Timer readouts count 5 ms steps
    localparam int TIME_STEP_US = 5000;
    localparam int BLOCK_LEAD_MS = 5;
    localparam int EVENT_STAMP_MS = 1;

    typedef struct packed {
        stage_operating_mode_t mode;
        logic force_enable;
        condition_t force_status;
        logic [3:0] harmonic_index;
        logic relative_mode;
        input_sel_t input_sel;
        logic [MAG_W-1:0] pickup_threshold;
        logic inverse_time;
        logic [TIME_W-1:0] operate_delay;
        logic [TIME_W-1:0] release_delay;
    } stage_settings_t;

    typedef struct packed {
        logic [MAG_W-1:0] phase_a;
        logic [MAG_W-1:0] phase_b;
        logic [MAG_W-1:0] phase_c;
    } three_mag_t;

    typedef struct packed {
        logic start_on;
        logic start_off;
        logic trip_on;
        logic trip_off;
        logic block_on;
        logic block_off;
    } stage_events_t;

endpackage : hoc_pkg

// ---- hdl/phase_compare.sv ----
// Per-phase threshold comparator with fixed reset ratio and ratio readout.
// Assumes magnitudes and threshold on the same fixed-point scale.
`timescale 1ns/1ns
module phase_compare #(
    parameter int MAG_W = 16,
    parameter int RATIO_W = 24
) (
    input wire logic mclk,
    input wire logic rst_sync_n,
    input wire logic tick,
    input wire logic [MAG_W-1:0] magnitude,
    input wire logic [MAG_W-1:0] threshold,
    output logic over,
    output logic [RATIO_W-1:0] ratio
);
    import hoc_pkg::*;

    initial begin
        if (RATIO_W < MAG_W + 7) $error("RATIO_W too narrow");
    end

    logic over_r, over_nxt;
    logic [RATIO_W-1:0] ratio_r, ratio_nxt;
    logic [MAG_W+7:0] mag_scaled, thr_reset;

    always_comb begin
        mag_scaled = (MAG_W+8)'(magnitude) * (MAG_W+8)'(100);
        thr_reset = (MAG_W+8)'(threshold) * (MAG_W+8)'(RESET_RATIO_PCT);
        over_nxt = over_r;
        ratio_nxt = ratio_r;
        if (tick) begin
            if (magnitude > threshold) begin
                over_nxt = 1'b1;
            end else if (mag_scaled < thr_reset) begin
                over_nxt = 1'b0;
            end
            // Ratio in hundredths; a zero threshold saturates
            if (threshold == '0) begin
                ratio_nxt = '1;
            end else begin
                ratio_nxt = RATIO_W'(mag_scaled / (MAG_W+8)'(threshold));
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            over_r <= 1'b0;
            ratio_r <= '0;
        end else begin
            over_r <= over_nxt;
            ratio_r <= ratio_nxt;
        end
    end

    assign over = over_r;
    assign ratio = ratio_r;
endmodule : phase_compare

// ---- hdl/delay_timer.sv ----
// Trip and release delay timer counting program-cycle ticks.
// Assumes delays in 5 ms steps, one tick per step.
`timescale 1ns/1ns
module delay_timer #(
    parameter int TIME_W = 20
) (
    input wire logic mclk,
    input wire logic rst_sync_n,
    input wire logic tick,
    input wire logic run,
    input wire logic inverse_time,
    input wire logic [TIME_W-1:0] delay,
    input wire logic [7:0] ratio_over,
    output logic expired,
    output logic [TIME_W-1:0] expected,
    output logic signed [TIME_W:0] remaining
);
    import hoc_pkg::*;

    logic [TIME_W-1:0] elapsed_r, elapsed_nxt;
    logic [TIME_W-1:0] expected_r, expected_nxt;
    logic [TIME_W-1:0] target;

    always_comb begin
        // Simple inverse shape: delay scaled down by the overshoot factor
        if (inverse_time && ratio_over > 8'h01) begin
            target = delay / TIME_W'(ratio_over);
        end else begin
            target = delay;
        end
        elapsed_nxt = elapsed_r;
        expected_nxt = expected_r;
        if (tick) begin
            expected_nxt = target;
            if (!run) begin
                elapsed_nxt = '0;
            end else if (elapsed_r != '1) begin
                elapsed_nxt = elapsed_r + TIME_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            elapsed_r <= '0;
            expected_r <= '0;
        end else begin
            elapsed_r <= elapsed_nxt;
            expected_r <= expected_nxt;
        end
    end

    assign expired = run && (elapsed_r >= target);
    assign expected = expected_r;
    assign remaining = $signed({1'b0, target}) - $signed({1'b0, elapsed_r});
endmodule : delay_timer

// ---- verification/hoc_checker_assertions.sv ----
// Port-level checker for one harmonic overcurrent stage.
// Assumes binding onto the stage top; forcing is off while block timing is judged.
`timescale 1ns/1ns
module hoc_checker
    import hoc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire hoc_pkg::stage_settings_t settings,
    input wire logic block_in,
    input wire logic start,
    input wire logic trip,
    input wire logic blocked,
    input wire hoc_pkg::stage_operating_mode_t behaviour,
    input wire hoc_pkg::condition_t condition,
    input wire hoc_pkg::stage_events_t events,
    input wire logic [31:0] event_stamp_ms,
    input wire logic block_display_event
);
    // ****************************************************
    // Block duration counter and properties
    // ****************************************************
    logic [5:0] blk_cnt_r;
    logic [5:0] blk_cnt_nxt;
    always_comb begin
        blk_cnt_nxt = blk_cnt_r;
        if (!block_in || settings.force_enable)
            blk_cnt_nxt = 6'h0;
        else if (blk_cnt_r != 6'h3f)
            blk_cnt_nxt = blk_cnt_r + 6'h1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            blk_cnt_r <= 6'h0;
        else
            blk_cnt_r <= blk_cnt_nxt;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_mode_readback: assert property (behaviour == settings.mode)
        else $error("behaviour differs from mode setting");
    a_pin_decode: assert property (start == (condition inside {COND_START, COND_TRIP}) &&
        trip == (condition == COND_TRIP) && blocked == (condition == COND_BLOCKED))
        else $error("output pins disagree with condition");
    a_off_idle: assert property ((settings.mode == MODE_OFF && !settings.force_enable)[*4]
        |-> condition == COND_NORMAL) else $error("stage active while off");
    a_force_hold: assert property ((settings.force_enable && $stable(settings.force_status))[*4]
        |-> condition == settings.force_status) else $error("forced status not shown");
    a_block_no_start: assert property (blk_cnt_r >= 6'h18 |-> !start)
        else $error("start stays up under block");
    a_trip_after_start: assert property ($rose(trip) && !settings.force_enable |-> $past(start))
        else $error("trip without prior start");
    a_start_event: assert property ($rose(start) |-> ##[0:1] events.start_on)
        else $error("start rise without event");
    a_trip_event: assert property ($rose(trip) |-> ##[0:1] events.trip_on)
        else $error("trip rise without event");
    a_block_event: assert property ($rose(blocked) |-> ##[0:1] events.block_on)
        else $error("blocked rise without event");
    a_display_event: assert property (block_display_event |-> events.block_on)
        else $error("display event without block event");
    a_stamp_step: assert property ($changed(event_stamp_ms)
        |-> event_stamp_ms == $past(event_stamp_ms) + 32'h1) else $error("stamp jumped");
    c_trip: cover property ($rose(trip));
    c_blocked: cover property ($rose(blocked));
    c_start_off: cover property (events.start_off);
endmodule : hoc_checker

// ---- verification/hoc_meas_model.sv ----
// Stand-in for the harmonic preprocessing and the blocking matrix.
// Assumes the bench sets magnitudes; program cycle shortened to PERIOD clocks.
`timescale 1ns/1ns
module hoc_meas_model
    import hoc_pkg::*;
#(
    parameter int PERIOD = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire hoc_pkg::three_mag_t ph,
    input wire logic [15:0] r1,
    input wire logic [15:0] r2,
    input wire logic [3:0] slot,
    input wire logic block_req,
    output logic cycle_tick,
    output logic [527:0] pci,
    output logic [175:0] res1,
    output logic [175:0] res2,
    output logic block_in
);
    logic [7:0] cnt_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h0;
            cycle_tick <= 1'b0;
            block_in <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h0 : cnt_r + 8'h1;
            cycle_tick <= (cnt_r == 8'(PERIOD - 1));
            // Bench raises block a full cycle ahead of any expiry
            block_in <= block_req;
        end
    end
    // Only the chosen order carries energy, so a wrong index reads zero
    always_comb begin
        pci = '0;
        res1 = '0;
        res2 = '0;
        pci[slot*16 +: 16] = ph.phase_a;
        pci[(11 + slot)*16 +: 16] = ph.phase_b;
        pci[(22 + slot)*16 +: 16] = ph.phase_c;
        res1[slot*16 +: 16] = r1;
        res2[slot*16 +: 16] = r2;
    end
endmodule : hoc_meas_model

// ---- verification/harmonic_overcurrent_stage_tb_top.sv ----
// Self-checking bench for one harmonic overcurrent stage.
// Assumes the model and checker files are compiled before this one.
`timescale 1ns/1ns
module harmonic_overcurrent_stage_tb_top;
    import hoc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    stage_settings_t s = '0;
    three_mag_t ph = '0;
    logic [15:0] r1 = 16'h0;
    logic [15:0] r2 = 16'h0;
    logic [3:0] slot = 4'h0;
    logic blk = 1'b0;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    logic [19:0] et;
    logic tick;
    logic blk_in;
    logic [527:0] pci;
    logic [175:0] res1;
    logic [175:0] res2;
    stage_operating_mode_t behaviour;
    condition_t condition;
    logic [19:0] expected_time;
    logic [23:0] ratio_now;
    three_mag_t bc;
    always #25 mclk = ~mclk;
    hoc_meas_model u_model (.mclk(mclk), .rst_n(rst_n), .ph(ph), .r1(r1), .r2(r2),
        .slot(slot), .block_req(blk), .cycle_tick(tick), .pci(pci), .res1(res1),
        .res2(res2), .block_in(blk_in));
    harmonic_overcurrent_stage #(.CLK_HZ(20000), .MS_COUNT(20)) uut (.mclk(mclk),
        .rst_n(rst_n), .cycle_tick(tick), .settings(s), .phase_current_inputs(pci),
        .residual_input_first(res1), .residual_input_second(res2),
        .phase_fundamental({3{16'h03e8}}), .residual_first_fundamental(16'h03e8),
        .residual_second_fundamental(16'h03e8), .block_in(blk_in), .start(), .trip(),
        .blocked(), .behaviour(behaviour), .condition(condition), .ratio_now(ratio_now),
        .expected_time(expected_time), .time_to_trip(), .events(), .event_stamp_ms(),
        .block_display_event(), .block_currents(bc), .block_fault_phases());
    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_cond(input condition_t exp);
        chk("condition", 24'(exp), 24'(condition));
    endtask : chk_cond
    // Bounded wait per tick so a dead tick source ends the run
    task automatic ticks(input int k);
        int w;
        for (int i = 0; i < k; i++) begin
            for (w = 0; w < 40 && tick !== 1'b1; w++)
                cyc(1);
            if (w == 40) begin
                miscompares++;
                print_verdict();
            end
            cyc(1);
        end
    endtask : ticks
    task automatic step(input logic [47:0] p, input logic [15:0] a, input logic [15:0] b,
        input logic k, input condition_t exp);
        ph = p;
        r1 = a;
        r2 = b;
        blk = k;
        ticks(4);
        chk_cond(exp);
    endtask : step
    initial begin
        s.mode = MODE_ON;
        s.pickup_threshold = THRESHOLD_PU_DEFAULT;
        s.operate_delay = 20'h000ff;
        cyc(20);
        rst_n = 1'b1;
        cyc(4);
        chk("behaviour", 24'h1, 24'(behaviour));
        step(48'h15, '0, '0, 1'b0, COND_START);
        step(48'h13, '0, '0, 1'b0, COND_NORMAL);
        s.pickup_threshold = 16'h0064;
        step(48'h65, '0, '0, 1'b0, COND_START);
        step(48'h62, '0, '0, 1'b0, COND_START);
        step(48'h60, '0, '0, 1'b0, COND_NORMAL);
        step(48'h0064_0000, '0, '0, 1'b0, COND_NORMAL);
        step(48'h0065_0000_0000, '0, '0, 1'b0, COND_START);
        slot = 4'h1;
        step(48'h00ff, '0, '0, 1'b0, COND_NORMAL);
        slot = 4'h0;
        s.input_sel = INPUT_RESIDUAL_FIRST;
        step(48'h00ff, '0, 16'h0065, 1'b0, COND_NORMAL);
        step('0, 16'h0065, '0, 1'b0, COND_START);
        s.input_sel = INPUT_RESIDUAL_SECOND;
        step('0, 16'h0065, '0, 1'b0, COND_NORMAL);
        step('0, '0, 16'h0065, 1'b0, COND_START);
        s.input_sel = INPUT_PHASES;
        step(48'h65, '0, '0, 1'b0, COND_START);
        step(48'h65, '0, '0, 1'b1, COND_BLOCKED);
        chk("block_currents", 24'h65, bc[23:0]);
        step('0, '0, '0, 1'b1, COND_NORMAL);
        step(48'h65, '0, '0, 1'b1, COND_BLOCKED);
        step(48'h65, '0, '0, 1'b0, COND_START);
        step('0, '0, '0, 1'b0, COND_NORMAL);
        s.operate_delay = 20'h00004;
        ph = 48'h0100;
        et = '0;
        for (n = 0; n < 12 && condition !== COND_TRIP; n++) begin
            ticks(1);
            if (condition === COND_START)
                et = expected_time;
        end
        chk_cond(COND_TRIP);
        chk("expected_time", 24'h4, 24'(et));
        chk("ratio_now", 24'h100, ratio_now);
        s.operate_delay = 20'h000ff;
        step('0, '0, '0, 1'b0, COND_NORMAL);
        s.mode = MODE_BLOCKED;
        step(48'h65, '0, '0, 1'b0, COND_BLOCKED);
        s.mode = MODE_TEST_BLOCKED;
        step(48'h65, '0, '0, 1'b0, COND_BLOCKED);
        s.mode = MODE_OFF;
        step(48'h65, '0, '0, 1'b0, COND_NORMAL);
        s.mode = MODE_TEST;
        step('0, '0, '0, 1'b0, COND_NORMAL);
        chk("behaviour", 24'h3, 24'(behaviour));
        s.mode = MODE_ON;
        for (int i = 0; i < 4; i++) begin
            s.force_enable = 1'b1;
            s.force_status = condition_t'(i);
            ticks(2);
            chk_cond(condition_t'(i));
        end
        s.force_enable = 1'b0;
        s.relative_mode = 1'b1;
        s.pickup_threshold = 16'h07d0;
        step(48'h00d2_0000_0000, '0, '0, 1'b0, COND_START);
        step(48'h00be_0000_0000, '0, '0, 1'b0, COND_NORMAL);
        print_verdict();
    end
endmodule : harmonic_overcurrent_stage_tb_top
bind harmonic_overcurrent_stage hoc_checker u_chk (.mclk, .rst_n, .settings, .block_in,
    .start, .trip, .blocked, .behaviour, .condition, .events, .event_stamp_ms,
    .block_display_event);
